// ==== verilog/mbpr_map.svh ====
// Purpose: constants of the macroblock picture reference parser
// Assumes: byte addresses on a 32-bit AXI4-Lite bus
`ifndef MBPR_MAP_SVH
`define MBPR_MAP_SVH
`define MBPR_A_CTRL 8'h00
`define MBPR_A_BUFCNT 8'h04
`define MBPR_A_TRREG 8'h08
`define MBPR_A_TRTAB 8'h0C
`define MBPR_A_STATUS 8'h10
`define MBPR_A_DIST 8'h14
`define MBPR_A_MBCNT 8'h18
`define MBPR_C_TYPE 1:0
`define MBPR_C_SLICE 2
`define MBPR_C_UMV 3
`define MBPR_C_ADV 4
`define MBPR_C_TWO 5
`define MBPR_C_START 7
`define MBPR_T_KIND 2:0
`define MBPR_T_BMVD 3
`define MBPR_T_FWD 4
`define MBPR_T_BWD 5
`define MBPR_K_4V 3'h2
`define MBPR_K_4VQ 3'h5
`define MBPR_K_INTRA 3'h3
`define MBPR_K_INTRAQ 3'h4
`define MBPR_RESP_OK 2'h0
`define MBPR_RESP_ERR 2'h2
`endif

// ==== verilog/mbpr_pkg.sv ====
// Purpose: types of the macroblock picture reference parser
// Assumes: nothing
// Notes: state codes double as the expected-field code for the symbol source
package mbpr_pkg;
    typedef enum logic [3:0] {
        ST_COD = 4'h0, ST_PR0 = 4'h1, ST_TYPE = 4'h3, ST_PR = 4'h2,
        ST_XREF = 4'h6, ST_PRB = 4'h7, ST_BSEL = 4'h5, ST_EMUL = 4'h4,
        ST_DONE = 4'hC
    } mbpr_state_t;
    typedef enum logic [1:0] {PIC_P = 2'h0, PIC_PB = 2'h1, PIC_B = 2'h2, PIC_EP = 2'h3} mbpr_pic_t;
    typedef struct packed {
        logic valid;
        logic [7:0] value;
    } mbpr_sym_t;
    typedef struct packed {
        logic valid;
        logic skipped;
        logic zero_mv;
        logic err;
        logic bwd_sel;
        logic [3:0] bpart_ref;
        logic [3:0] fwd_slot;
        logic [15:0] refs;
    } mbpr_mb_t;
endpackage : mbpr_pkg

// ==== verilog/mbpr_parser.sv ====
// Purpose: macroblock picture reference parsing and reference selection
// Assumes: symbols arrive already variable-length decoded, on aclk
// Notes: expect tells the symbol source which field is taken next
`timescale 1ns/1ns
`default_nettype none
`include "mbpr_map.svh"
module mbpr_parser (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // symbol stream
    input wire mbpr_pkg::mbpr_sym_t sym_in,
    output logic sym_ready,
    output logic [3:0] expect_field,
    // macroblock result and distances
    output mbpr_pkg::mbpr_mb_t mb_out,
    output logic [7:0] full_temporal_distance,
    output logic [7:0] bside_temporal_distance
);
    import mbpr_pkg::*;

    function automatic logic need_emul(input logic [7:0] v, input logic umv);
        need_emul = (v == 8'h01) && !umv;
    endfunction : need_emul

    function automatic logic [7:0] tr_diff(input logic [7:0] later, input logic [7:0] earlier);
        tr_diff = later - earlier;
    endfunction : tr_diff

    mbpr_state_t state;
    mbpr_state_t ret_state;
    mbpr_state_t after_pr;
    mbpr_state_t after_x;
    logic [7:0] ctrl;
    logic [3:0] buf_cnt;
    logic [7:0] tr_cur;
    logic [7:0] tr_prev;
    logic [7:0] tr_bpart;
    logic [7:0] tr_tab [0:15];
    logic pic_start;
    logic prev_one_noemul;
    logic [1:0] xcnt;
    logic [7:0] type_val;
    logic [15:0] mb_cnt;
    logic [7:0] err_cnt;
    logic take;
    logic [7:0] v;
    logic bpic;
    logic two_bwd;
    logic [3:0] bwd_cnt;
    logic [3:0] fwd_size;
    logic [3:0] fwd0;
    logic wr_go;
    mbpr_mb_t res;

    assign v = sym_in.value;
    assign bpic = ctrl[`MBPR_C_TYPE] == PIC_B || ctrl[`MBPR_C_TYPE] == PIC_EP;
    assign two_bwd = ctrl[`MBPR_C_TYPE] == PIC_B && ctrl[`MBPR_C_TWO];
    // backward set is the head of the picture-level order, rest is forward
    assign bwd_cnt = ctrl[`MBPR_C_TYPE] != PIC_B ? 4'h0 : (two_bwd ? 4'h2 : 4'h1);
    assign fwd_size = buf_cnt - bwd_cnt;
    assign fwd0 = bwd_cnt;
    assign sym_ready = state != ST_DONE && !pic_start;
    assign take = sym_in.valid && sym_ready;
    assign expect_field = state;

    always_comb begin
        if (bpic) begin
            after_pr = (type_val[`MBPR_T_BWD] && two_bwd) ? ST_BSEL : ST_DONE;
        end else if ((type_val[`MBPR_T_KIND] == `MBPR_K_4V || type_val[`MBPR_T_KIND] == `MBPR_K_4VQ)
                     && ctrl[`MBPR_C_ADV]) begin
            after_pr = ST_XREF;
        end else if (ctrl[`MBPR_C_TYPE] == PIC_PB && type_val[`MBPR_T_BMVD]) begin
            after_pr = ST_PRB;
        end else begin
            after_pr = ST_DONE;
        end
        after_x = (ctrl[`MBPR_C_TYPE] == PIC_PB && type_val[`MBPR_T_BMVD]) ? ST_PRB : ST_DONE;
    end

    // parse sequencing
    always_ff @(posedge aclk) begin
        if (!aresetn || pic_start) begin
            state <= ST_COD;
            ret_state <= ST_DONE;
            xcnt <= 2'h0;
            type_val <= 8'h00;
        end else begin
            case (state)
                ST_COD: if (take) begin
                    state <= v[0] ? ST_DONE : ST_PR0;
                end
                ST_PR0: if (take) begin
                    if (v == 8'h00) begin
                        state <= ST_TYPE;
                    end else if (v == 8'h01 && (ctrl[`MBPR_C_SLICE] || prev_one_noemul)) begin
                        state <= ST_EMUL;
                        ret_state <= ST_DONE;
                    end else begin
                        state <= ST_DONE;
                    end
                end
                ST_TYPE: if (take) begin
                    type_val <= v;
                    if (bpic) begin
                        if (v[`MBPR_T_FWD]) begin
                            state <= ST_PR;
                        end else if (v[`MBPR_T_BWD] && two_bwd) begin
                            state <= ST_BSEL;
                        end else begin
                            state <= ST_DONE;
                        end
                    end else if ((v[`MBPR_T_KIND] != `MBPR_K_INTRA && v[`MBPR_T_KIND] != `MBPR_K_INTRAQ)
                                 || ctrl[`MBPR_C_TYPE] == PIC_PB) begin
                        state <= ST_PR;
                    end else begin
                        state <= ST_DONE;
                    end
                end
                ST_PR: if (take) begin
                    xcnt <= 2'h0;
                    if (need_emul(v, ctrl[`MBPR_C_UMV])) begin
                        state <= ST_EMUL;
                        ret_state <= after_pr;
                    end else begin
                        state <= after_pr;
                    end
                end
                ST_XREF: if (take) begin
                    xcnt <= xcnt + 2'h1;
                    if (need_emul(v, ctrl[`MBPR_C_UMV])) begin
                        state <= ST_EMUL;
                        ret_state <= xcnt == 2'h2 ? after_x : ST_XREF;
                    end else if (xcnt == 2'h2) begin
                        state <= after_x;
                    end
                end
                ST_PRB: if (take) begin
                    if (need_emul(v, ctrl[`MBPR_C_UMV])) begin
                        state <= ST_EMUL;
                        ret_state <= ST_DONE;
                    end else begin
                        state <= ST_DONE;
                    end
                end
                ST_EMUL: if (take) begin
                    state <= ret_state;
                end
                ST_BSEL: if (take) begin
                    state <= ST_DONE;
                end
                ST_DONE: begin
                    state <= ST_COD;
                end
                default: begin
                    state <= ST_COD;
                end
            endcase
        end
    end

    // one-without-emulation-bit memory across adjacent macroblocks
    always_ff @(posedge aclk) begin
        if (!aresetn || pic_start) begin
            prev_one_noemul <= 1'b0;
        end else if (take && state == ST_COD && v[0]) begin
            prev_one_noemul <= 1'b0;
        end else if (take && state == ST_PR0) begin
            prev_one_noemul <= v == 8'h01 && !(ctrl[`MBPR_C_SLICE] || prev_one_noemul);
        end
    end

    // result of the macroblock under way
    always_ff @(posedge aclk) begin
        if (!aresetn || pic_start) begin
            res <= '0;
        end else if (take) begin
            case (state)
                ST_COD: begin
                    res <= '{fwd_slot: fwd0, default: '0};
                    res.skipped <= v[0];
                    res.zero_mv <= v[0];
                end
                ST_PR0: if (v != 8'h00) begin
                    res.zero_mv <= 1'b1;
                    res.refs <= {4{v[3:0]}};
                    res.fwd_slot <= v[3:0] + fwd0;
                    res.err <= v[3:0] >= fwd_size || v[7:4] != 4'h0;
                end
                ST_PR: begin
                    // whole macroblock, or block one and chroma when extras follow
                    res.refs <= {4{v[3:0]}};
                    res.fwd_slot <= v[3:0] + fwd0;
                    res.err <= res.err || v[3:0] >= fwd_size || v[7:4] != 4'h0;
                end
                ST_XREF: begin
                    res.refs[4 * (xcnt + 2'h1) +: 4] <= v[3:0];
                    res.err <= res.err || v[3:0] >= fwd_size || v[7:4] != 4'h0;
                end
                ST_PRB: begin
                    res.bpart_ref <= v[3:0];
                    res.err <= res.err || v[3:0] >= fwd_size || v[7:4] != 4'h0;
                end
                ST_EMUL: begin
                    res.err <= res.err || !v[0];
                end
                ST_BSEL: begin
                    res.bwd_sel <= v[0];
                    res.err <= res.err || v[7:1] != 7'h00;
                end
                default: begin
                    res.valid <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mb_out <= '0;
            mb_cnt <= 16'h0000;
            err_cnt <= 8'h00;
        end else begin
            mb_out <= res;
            mb_out.valid <= state == ST_DONE;
            if (state == ST_DONE) begin
                mb_cnt <= mb_cnt + 16'h0001;
                err_cnt <= err_cnt + {7'h00, res.err};
            end
        end
    end

    // distances follow the picture-level table and tr_cur, or tr_cur, tr_prev and tr_bpart in pb pictures; slice remaps never touch it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            full_temporal_distance <= 8'h00;
            bside_temporal_distance <= 8'h00;
        end else if (ctrl[`MBPR_C_TYPE] == PIC_PB) begin
            full_temporal_distance <= tr_diff(tr_cur, tr_prev);
            bside_temporal_distance <= tr_diff(tr_bpart, tr_prev);
        end else begin
            full_temporal_distance <= tr_diff(tr_tab[4'h0], tr_tab[fwd0]);
            bside_temporal_distance <= tr_diff(tr_cur, tr_tab[fwd0]);
        end
    end

    // axi4-lite slave: address and data are taken together, one write at a time
    assign wr_go = s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid;
    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= 8'h00;
            buf_cnt <= 4'h0;
            tr_cur <= 8'h00;
            tr_prev <= 8'h00;
            tr_bpart <= 8'h00;
            pic_start <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MBPR_RESP_OK;
        end else begin
            pic_start <= wr_go && s_axi_awaddr == `MBPR_A_CTRL && s_axi_wstrb[0] && s_axi_wdata[`MBPR_C_START];
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= `MBPR_RESP_OK;
                case (s_axi_awaddr)
                    `MBPR_A_CTRL: if (s_axi_wstrb[0]) begin
                        ctrl <= {1'b0, s_axi_wdata[6:0]};
                    end
                    `MBPR_A_BUFCNT: if (s_axi_wstrb[0]) begin
                        buf_cnt <= s_axi_wdata[3:0];
                    end
                    `MBPR_A_TRREG: begin
                        if (s_axi_wstrb[0]) tr_cur <= s_axi_wdata[7:0];
                        if (s_axi_wstrb[1]) tr_prev <= s_axi_wdata[15:8];
                        if (s_axi_wstrb[2]) tr_bpart <= s_axi_wdata[23:16];
                    end
                    `MBPR_A_TRTAB: begin
                        s_axi_bresp <= `MBPR_RESP_OK;
                    end
                    default: begin
                        s_axi_bresp <= `MBPR_RESP_ERR;
                    end
                endcase
            end
        end
    end

    // table of picture-level temporal references, index in bits 11:8
    always_ff @(posedge aclk) begin
        if (wr_go && s_axi_awaddr == `MBPR_A_TRTAB && s_axi_wstrb[0]) begin
            tr_tab[s_axi_wdata[11:8]] <= s_axi_wdata[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `MBPR_RESP_OK;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else if (s_axi_arvalid) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `MBPR_RESP_OK;
            case (s_axi_araddr)
                `MBPR_A_CTRL: s_axi_rdata <= {24'h000000, ctrl};
                `MBPR_A_BUFCNT: s_axi_rdata <= {28'h0000000, buf_cnt};
                `MBPR_A_TRREG: s_axi_rdata <= {8'h00, tr_bpart, tr_prev, tr_cur};
                `MBPR_A_TRTAB: s_axi_rdata <= 32'h00000000;
                `MBPR_A_STATUS: s_axi_rdata <= {12'h000, state, err_cnt, 7'h00, prev_one_noemul};
                `MBPR_A_DIST: s_axi_rdata <= {16'h0000, bside_temporal_distance, full_temporal_distance};
                `MBPR_A_MBCNT: s_axi_rdata <= {16'h0000, mb_cnt};
                default: begin
                    s_axi_rdata <= 32'h00000000;
                    s_axi_rresp <= `MBPR_RESP_ERR;
                end
            endcase
        end
    end

    chk_skip_done: assert property (@(posedge aclk) disable iff (!aresetn)
        take && state == ST_COD && v[0] |=> state == ST_DONE ##1 mb_out.valid && mb_out.skipped)
        else $error("skipped macroblock did not finish");
    chk_zero_type: assert property (@(posedge aclk) disable iff (!aresetn)
        take && state == ST_PR0 && v == 8'h00 |=> state == ST_TYPE)
        else $error("type field not expected after zero parameter");
    chk_slice_emul: assert property (@(posedge aclk) disable iff (!aresetn)
        take && state == ST_PR0 && v == 8'h01 && ctrl[`MBPR_C_SLICE] |=> state == ST_EMUL)
        else $error("missing emulation bit in slice mode");
    chk_chain_emul: assert property (@(posedge aclk) disable iff (!aresetn)
        take && state == ST_PR0 && v == 8'h01 && !ctrl[`MBPR_C_SLICE] && !prev_one_noemul
        |=> state == ST_DONE && prev_one_noemul)
        else $error("emulation bit expected without cause");
    chk_skip_param: assert property (@(posedge aclk) disable iff (!aresetn || pic_start)
        take && state == ST_PR0 && v > 8'h01 |=> state == ST_DONE ##1 mb_out.valid && mb_out.zero_mv
        && mb_out.refs[3:0] == $past(v[3:0], 2))
        else $error("skip parameter not reported as reference");
    chk_ref_emul: assert property (@(posedge aclk) disable iff (!aresetn || pic_start)
        take && (state == ST_PR || state == ST_PRB) && v == 8'h01 |=> (state == ST_EMUL) == !$past(ctrl[3]))
        else $error("reference emulation bit mismatch");
    chk_xref_count: assert property (@(posedge aclk) disable iff (!aresetn || pic_start)
        state == ST_XREF && take && xcnt == 2'h2 |=> state != ST_XREF || ret_state != ST_XREF)
        else $error("more than three extra references");
    chk_pic_clear: assert property (@(posedge aclk) disable iff (!aresetn)
        pic_start |=> !prev_one_noemul && state == ST_COD)
        else $error("picture start did not clear parser");
    chk_range_err: assert property (@(posedge aclk) disable iff (!aresetn || pic_start)
        take && state == ST_PR && {4'h0, fwd_size} <= v |=> res.err)
        else $error("out of range reference not flagged");
    cov_skip: cover property (@(posedge aclk) take && state == ST_COD && v[0]);
    cov_four_vector: cover property (@(posedge aclk) state == ST_XREF ##1 state == ST_EMUL);
    cov_bpart: cover property (@(posedge aclk) state == ST_PRB && take);
    cov_bsel: cover property (@(posedge aclk) state == ST_BSEL && take && v[0]);
endmodule : mbpr_parser
`default_nettype wire

// ==== sim/mbpr_encoder_model.sv ====
// Purpose: encoder side that sends decoded macroblock fields one by one
// Assumes: one field per symbol, the bench chooses field order
// Notes: a released value line shows the inverse of the last field
`timescale 1ns/1ns
`default_nettype none
module mbpr_encoder_model (
    // clock and handshake
    input wire logic aclk,
    input wire logic sym_ready,
    // symbol out
    output var mbpr_pkg::mbpr_sym_t sym_out
);
    import mbpr_pkg::*;
    initial sym_out = '0;
    // fields leave exactly in the order given
    task automatic put(input logic [7:0] v);
        logic g;
        @(posedge aclk);
        sym_out <= '{valid: 1'b1, value: v};
        do begin
            @(negedge aclk);
            g = sym_ready;
            @(posedge aclk);
        end while (!g);
        sym_out <= '{valid: 1'b0, value: ~v};
    endtask : put
endmodule : mbpr_encoder_model
`default_nettype wire

// ==== sim/mb_picture_reference_parser_bench.sv ====
// Purpose: self-checking bench for mbpr_parser
// Assumes: encoder model feeds symbols, bench is the bus master
// Notes: expectations come from the ctrl and table values written
`timescale 1ns/1ns
`default_nettype none
module mb_picture_reference_parser_bench;
    import mbpr_pkg::*;
    logic aclk = 0, aresetn = 0, g;
    logic [7:0] awaddr = 0, araddr = 0, full_d, bside_d;
    logic [31:0] wdata = 0, rdata, rv;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, sym_ready;
    logic [1:0] bresp, rresp, resp;
    logic [3:0] expect_field;
    mbpr_sym_t sym;
    mbpr_mb_t mbo;
    int failures = 0, cmp_count = 0;
    always #4 aclk = ~aclk;
    mbpr_parser dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sym_in(sym),
        .sym_ready(sym_ready), .expect_field(expect_field), .mb_out(mbo),
        .full_temporal_distance(full_d), .bside_temporal_distance(bside_d));
    mbpr_encoder_model enc (.aclk(aclk), .sym_ready(sym_ready), .sym_out(sym));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
        cmp_count++;
        if (v !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", n, e, v);
        end
    endtask : chk
    task automatic until_hi(ref logic s);
        do begin
            @(negedge aclk);
            g = s;
            @(posedge aclk);
        end while (!g);
    endtask : until_hi
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ga, gw;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // each channel is released on the edge at which its own ready was high
        do begin
            @(negedge aclk);
            ga = awready && awvalid;
            gw = wready && wvalid;
            @(posedge aclk);
            if (ga) awvalid <= 1'b0;
            if (gw) wvalid <= 1'b0;
        end while ((awvalid && !ga) || (wvalid && !gw));
        until_hi(bvalid);
        resp = bresp;
        bready <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        until_hi(arready);
        arvalid <= 1'b0;
        until_hi(rvalid);
        rv = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask : rd
    // fields: skipped, err, bwd_sel, fwd_slot, refs
    task automatic mbq(input logic [7:0] s[$], input logic [22:0] e, input logic [22:0] m);
        int i;
        i = 0;
        foreach (s[k]) enc.put(s[k]);
        do @(negedge aclk); while (mbo.valid !== 1'b1 && ++i < 200);
        chk("mb_valid", 32'h1, {31'h0, mbo.valid});
        chk("mb_out", e & m, {mbo.skipped, mbo.err, mbo.bwd_sel, mbo.fwd_slot, mbo.refs} & m);
    endtask : mbq
    task automatic wrap_up();
        $display("checks %0d failures %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : wrap_up
    initial begin
        repeat (20000) @(posedge aclk);
        failures++;
        wrap_up();
    end
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(8'h10);
        chk("status", 32'h0, rv);
        rd(8'h1C);
        chk("rresp", 2'h2, resp);
        wr(8'h1C, 32'h0);
        chk("bresp", 2'h2, resp);
        // p picture, advanced prediction, picture start
        // eight buffered pictures keep every reference below in range
        wr(8'h00, 32'h90);
        wr(8'h04, 32'h8);
        mbq('{8'h00, 8'h02}, 23'h002222, 23'h60FFFF);
        chk("zero_mv", 1'b1, mbo.zero_mv);
        mbq('{8'h01}, 23'h400000, 23'h60FFFF);
        chk("zero_mv", 1'b1, mbo.zero_mv);
        mbq('{8'h00, 8'h01}, 23'h001111, 23'h60FFFF);
        rd(8'h10);
        chk("one_no_bit", 1'b1, rv[0]);
        mbq('{8'h00, 8'h01, 8'h01}, 23'h001111, 23'h60FFFF);
        rd(8'h10);
        chk("one_no_bit", 1'b0, rv[0]);
        mbq('{8'h00, 8'h00, 8'h03}, 23'h000000, 23'h60FFFF);
        enc.put(8'h00);
        enc.put(8'h00);
        @(negedge aclk);
        chk("expect", 4'h3, expect_field);
        mbq('{8'h02, 8'h01, 8'h01, 8'h01, 8'h01, 8'h05, 8'h06}, 23'h016511, 23'h6FFFFF);
        // slice mode forces the bit after a one
        wr(8'h00, 32'h94);
        mbq('{8'h00, 8'h01, 8'h01}, 23'h001111, 23'h60FFFF);
        // improved pb frame with b-part vector, unrestricted vectors on
        wr(8'h00, 32'h89);
        wr(8'h08, 32'h001A161E);
        mbq('{8'h00, 8'h00, 8'h08, 8'h01, 8'h05}, 23'h001111, 23'h60FFFF);
        chk("bpart_ref", 4'h5, mbo.bpart_ref);
        chk("dist_pb", 16'h0408, {bside_d, full_d});
        mbq('{8'h00, 8'h00, 8'h03, 8'h02}, 23'h002222, 23'h60FFFF);
        // b picture, two-picture backward, five buffered
        wr(8'h00, 32'hA2);
        wr(8'h04, 32'h5);
        wr(8'h0C, 32'h0014);
        wr(8'h0C, 32'h020C);
        wr(8'h08, 32'h0F);
        repeat (2) @(negedge aclk);
        chk("dist_b", 16'h0308, {bside_d, full_d});
        rd(8'h14);
        chk("dist_reg", 32'h0308, rv);
        enc.put(8'h00);
        enc.put(8'h00);
        @(negedge aclk);
        chk("expect", 4'h3, expect_field);
        mbq('{8'h30, 8'h02, 8'h01}, 23'h140000, 23'h3F0000);
        mbq('{8'h00, 8'h00, 8'h10, 8'h03}, 23'h200000, 23'h200000);
        mbq('{8'h00, 8'h02}, 23'h042222, 23'h6FFFFF);
        chk("zero_mv", 1'b1, mbo.zero_mv);
        mbq('{8'h01}, 23'h420000, 23'h7F0000);
        // ep picture: no backward set, so no selection bit after the reference
        wr(8'h00, 32'h83);
        mbq('{8'h00, 8'h00, 8'h30, 8'h02}, 23'h022222, 23'h7FFFFF);
        mbq('{8'h01}, 23'h400000, 23'h7F0000);
        wrap_up();
    end
endmodule : mb_picture_reference_parser_bench
`default_nettype wire
